// File: design/isc_defines.svh
// Register offsets, field positions, reset values and timing counts of the two-wire status block.
`ifndef ISC_DEFINES_SVH
`define ISC_DEFINES_SVH
`define ISC_OFF_STATUS 8'h00
`define ISC_OFF_CTRL_ONE 8'h04
`define ISC_OFF_CTRL_ZERO 8'h08
`define ISC_OFF_CLKSEL 8'h0C
`define ISC_OFF_TIMING 8'h10
`define ISC_OFF_DATA 8'h14
`define ISC_OFF_CTRL_TWO 8'h18
`define ISC_OFF_PORT 8'h1C
`define ISC_OFF_OWN_ADDR 8'h20
`define ISC_ST_AMATCH 2
`define ISC_ST_AL 3
`define ISC_ST_PENDING 4
`define ISC_ST_BUSY 5
`define ISC_ST_DIR 6
`define ISC_ST_MST 7
`define ISC_C1_SIM 0
`define ISC_C1_WIT 1
`define ISC_C1_PED 2
`define ISC_C1_PEC 3
`define ISC_C1_DATA_OUT_MONITOR 4
`define ISC_C1_CLOCK_OUT_MONITOR 5
`define ISC_C0_ENABLE 3
`define ISC_C0_FREE 4
`define ISC_C0_SRST 6
`define ISC_CK_PCLK 3
`define ISC_CK_WCS 4
`define ISC_C2_ACKBIT 0
`define ISC_C2_ACKCLK 1
`define ISC_RST_TIMING 5'h0_00A
`define ISC_RST_OWN_ADDR 7'h0_000
`define ISC_HALF_BIT 4'h0_008
`define ISC_HI_MAX 5'h0_01F
`endif

// File: design/isc_pkg.sv
// Types of the two-wire status block.
package isc_pkg;
   typedef enum logic [2:0] {PH_IDLE, PH_BITS, PH_HOLD, PH_ACK, PH_DONE} isc_phase_t;
   typedef struct packed {
      logic s1_scl, s2_scl, s1_sda, s2_sda, scl_q, sda_q;
      logic [4:0] hi_cnt, acc;
      logic f2_tog, busy, dir, master_slave_bit, pending, amatch, al, lost, prot, addr_phase, involved, wait_f;
      logic sim, rx_done_irq_enable, data_pin_override, clock_pin_override, pclk_sel, wcs, enable, free_fmt, ack_clk, ack_bit, latch_sda, latch_scl;
      logic [4:0] ick, sstime;
      logic [6:0] own_addr;
      logic [7:0] shift;
      logic [3:0] bitcnt, half;
      isc_phase_t phase;
      logic scl_gen, sda_gen, irq, slverr;
      logic [31:0] prdata;
   } isc_state_t;
endpackage

// File: design/isc_status_mode_ctrl.sv
// Status, mode and control logic of a multi-master two-wire bus interface with an APB register slave.
`timescale 1ns/1ps
`default_nettype none
`include "isc_defines.svh"
//
// Behaviour
// - Bus busy set on detected START, cleared on detected STOP, any mode.
// - Bus busy cleared when interface disabled or soft reset requested.
// - Timing field sets how long the clock must be high to qualify conditions.
// - Direction 0 receives; direction 1 drives data on the data line.
// - Addressed slave with matching address and read bit sets direction.
// - Direction cleared on arbitration loss, STOP, START, slave nack, disable, reset.
// - Master bit 0 follows external clock; 1 generates the bus clock.
// - Master bit cleared after lost byte, on STOP, START, reset or disable.
// - Mode and direction writes ignored from busy rise until address received.
// - Stop interrupt enable raises request on STOP without touching pending.
// - Receive-done enable with ack clock interrupts and holds clock at last bit.
// - After restart, pending clears and request rises at ack clock fall.
// - Receive-done bit reads wait flag; data write sets it, control two clears.
// - Wait flag stays 0 when transmitting or receiving the first address.
// - Override bits drive the pins from port latches; inputs still used.
// - Monitor bits read internal data and clock output values.
// - Five select bits choose divide by 2, 4, 8, 2.5, 3, 5 or 6.
// - Divider source is one of two peripheral clocks, chosen by a bit.
// - Runs in wait mode unless clock stopped; halts in stop or low power.
// - While busy and pending is 0 the clock line is held low.
//
module isc_status_mode_ctrl
   import isc_pkg::*;
(
   // Clock and reset.
   input wire logic CLK,
   input wire logic SRST,
   // APB slave.
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Two-wire bus pins.
   input wire logic SCL_I,
   output logic SCL_O,
   output logic SCL_OE,
   input wire logic SDA_I,
   output logic SDA_O,
   output logic SDA_OE,
   // Power modes and interrupt request.
   input wire logic WAIT_MODE,
   input wire logic STOP_MODE,
   output logic IRQ
);
   import isc_pkg::*;

   isc_state_t s;
   isc_state_t n;

   ////////////////////////////////////////////////////////////////////////////////
   // Divider period in half source cycles.
   function automatic logic [4:0] div_half(input logic [4:0] sel);
      logic [4:0] r;
      r = 5'h0_004;
      casez (sel)
         5'b00000: r = 5'h0_004;
         5'b00001: r = 5'h0_008;
         5'b00010: r = 5'h0_010;
         5'b001??: r = 5'h0_005;
         5'b010??: r = 5'h0_006;
         5'b011??: r = 5'h0_00A;
         5'b100??: r = 5'h0_00C;
         default: r = 5'h0_004;
      endcase
      return r;
   endfunction

   logic wr, rd, mapped, run, src_tick, vtick, scl_int;
   logic [5:0] acc_sum;
   assign wr = PSEL && PENABLE && PWRITE;
   assign rd = PSEL && !PENABLE && !PWRITE;
   always_comb
   begin
      case (PADDR)
         `ISC_OFF_STATUS, `ISC_OFF_CTRL_ONE, `ISC_OFF_CTRL_ZERO, `ISC_OFF_CLKSEL, `ISC_OFF_TIMING,
         `ISC_OFF_DATA, `ISC_OFF_CTRL_TWO, `ISC_OFF_PORT, `ISC_OFF_OWN_ADDR: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end
   // no bus clock in stop mode or in wait mode with the clock stopped
   assign run = s.enable && !STOP_MODE && !(WAIT_MODE && s.wcs);
   // second source runs at half the first
   assign src_tick = s.pclk_sel ? s.f2_tog : 1'b1;
   assign acc_sum = {1'b0, s.acc} + 6'h0_002;
   assign vtick = run && src_tick && (acc_sum >= {1'b0, div_half(s.ick)});
   // clock held low while busy with a request pending
   assign scl_int = s.scl_gen && !(s.busy && !s.pending);

   ////////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      logic scl_s, sda_s, rise, fall, start_c, stop_c, match, wait_eff;
      logic [7:0] rv;
      n = s;
      scl_s = s.s2_scl;
      sda_s = s.s2_sda;
      rise = 1'b0;
      fall = 1'b0;
      start_c = 1'b0;
      stop_c = 1'b0;
      match = 1'b0;
      wait_eff = 1'b0;
      rv = 8'h0_000;
      n.irq = 1'b0;
      n.s1_scl = SCL_I;
      n.s2_scl = s.s1_scl;
      n.s1_sda = SDA_I;
      n.s2_sda = s.s1_sda;
      n.f2_tog = !s.f2_tog;
      if (run && src_tick)
      begin
         n.acc = vtick ? 5'(acc_sum - {1'b0, div_half(s.ick)}) : acc_sum[4:0];
      end

      // Register reads are captured in the setup phase.
      case (PADDR)
         `ISC_OFF_STATUS: rv = {s.master_slave_bit, s.dir, s.busy, s.pending, s.al, s.amatch, 2'b00};
         // receive-done bit reads the wait flag
         `ISC_OFF_CTRL_ONE: rv = {s.ick[1:0], scl_int, s.sda_gen, s.clock_pin_override, s.data_pin_override, s.wait_f, s.sim};
         `ISC_OFF_CTRL_ZERO: rv = {3'b000, s.free_fmt, s.enable, 3'b000};
         `ISC_OFF_CLKSEL: rv = {3'b000, s.wcs, s.pclk_sel, s.ick[4:2]};
         `ISC_OFF_TIMING: rv = {3'b000, s.sstime};
         `ISC_OFF_DATA: rv = s.shift;
         `ISC_OFF_CTRL_TWO: rv = {6'b000000, s.ack_clk, s.ack_bit};
         `ISC_OFF_PORT: rv = {6'b000000, s.latch_scl, s.latch_sda};
         `ISC_OFF_OWN_ADDR: rv = {1'b0, s.own_addr};
         default: rv = 8'h0_000;
      endcase
      if (rd)
      begin
         n.prdata = {24'h00_0000, rv};
      end
      n.slverr = PSEL && !PENABLE && !mapped;

      // Register writes.
      if (wr)
      begin
         case (PADDR)
            `ISC_OFF_STATUS:
            begin
               // mode writes ignored while duplicate protection holds
               if (!s.prot)
               begin
                  n.master_slave_bit = PWDATA[`ISC_ST_MST];
                  n.dir = PWDATA[`ISC_ST_DIR];
               end
               // restart from held state by setting pending
               if (PWDATA[`ISC_ST_PENDING])
               begin
                  n.pending = 1'b1;
               end
            end
            `ISC_OFF_CTRL_ONE:
            begin
               n.sim = PWDATA[`ISC_C1_SIM];
               n.rx_done_irq_enable = PWDATA[`ISC_C1_WIT];
               n.data_pin_override = PWDATA[`ISC_C1_PED];
               n.clock_pin_override = PWDATA[`ISC_C1_PEC];
               n.ick[1:0] = PWDATA[7:6];
            end
            `ISC_OFF_CTRL_ZERO:
            begin
               n.enable = PWDATA[`ISC_C0_ENABLE];
               n.free_fmt = PWDATA[`ISC_C0_FREE];
            end
            `ISC_OFF_CLKSEL:
            begin
               n.ick[4:2] = PWDATA[2:0];
               n.pclk_sel = PWDATA[`ISC_CK_PCLK];
               n.wcs = PWDATA[`ISC_CK_WCS];
            end
            `ISC_OFF_TIMING: n.sstime = PWDATA[4:0];
            `ISC_OFF_DATA:
            begin
               // data write starts the next byte
               // data write sets the wait flag when receiving past the address byte
               n.shift = PWDATA[7:0];
               n.pending = 1'b1;
               n.wait_f = !s.dir && !s.addr_phase;
               n.al = 1'b0;
               n.amatch = 1'b0;
               n.bitcnt = 4'h0_000;
               n.half = 4'h0_000;
               if (s.busy)
               begin
                  n.phase = PH_BITS;
                  n.involved = 1'b1;
               end
               // transmit places the first bit on the data line
               n.sda_gen = s.dir ? PWDATA[7] : 1'b1;
            end
            `ISC_OFF_CTRL_TWO:
            begin
               n.ack_bit = PWDATA[`ISC_C2_ACKBIT];
               n.ack_clk = PWDATA[`ISC_C2_ACKCLK];
               // control two write clears the wait flag
               n.wait_f = 1'b0;
               if (s.rx_done_irq_enable && s.wait_f)
               begin
                  n.pending = 1'b1;
               end
            end
            `ISC_OFF_PORT:
            begin
               n.latch_sda = PWDATA[0];
               n.latch_scl = PWDATA[1];
            end
            `ISC_OFF_OWN_ADDR: n.own_addr = PWDATA[6:0];
            default: n.prdata = s.prdata;
         endcase
      end

      if (n.phase == PH_HOLD && n.pending)
      begin
         n.phase = PH_ACK;
         n.sda_gen = s.dir ? 1'b1 : s.ack_bit;
      end

      ////////////////////////////////////////////////////////////////////////////
      // Bus logic, advanced once per bus clock tick.
      if (vtick)
      begin
         n.scl_q = scl_s;
         n.sda_q = sda_s;
         rise = scl_s && !s.scl_q;
         fall = !scl_s && s.scl_q;
         n.hi_cnt = !scl_s ? 5'h0_000 : (s.hi_cnt == `ISC_HI_MAX ? s.hi_cnt : 5'(s.hi_cnt + 5'h0_001));
         // conditions need the clock high for the programmed time
         start_c = scl_s && s.scl_q && s.sda_q && !sda_s && (s.hi_cnt >= s.sstime);
         stop_c = scl_s && s.scl_q && !s.sda_q && sda_s && (s.hi_cnt >= s.sstime);
         // master generates the clock during active phases
         if (s.master_slave_bit && s.busy && s.pending && (s.phase == PH_BITS || s.phase == PH_ACK))
         begin
            if (s.half == `ISC_HALF_BIT - 4'h0_001)
            begin
               n.half = 4'h0_000;
               n.scl_gen = !s.scl_gen;
            end
            else
            begin
               n.half = 4'(s.half + 4'h0_001);
            end
         end
         else if (!s.master_slave_bit)
         begin
            n.scl_gen = 1'b1;
         end
         if (rise && s.phase == PH_BITS)
         begin
            n.shift = {s.shift[6:0], sda_s};
            n.bitcnt = 4'(s.bitcnt + 4'h0_001);
            if (s.master_slave_bit && s.dir && s.sda_gen && !sda_s)
            begin
               n.al = 1'b1;
               n.dir = 1'b0;
               n.lost = 1'b1;
               n.sda_gen = 1'b1;
            end
         end
         if (rise && s.phase == PH_ACK && s.dir && !s.master_slave_bit && sda_s)
         begin
            n.dir = 1'b0;
         end
         if (fall && s.phase == PH_BITS && s.bitcnt != 4'h0_008)
         begin
            n.sda_gen = s.dir && !s.lost ? s.shift[7] : 1'b1;
         end
         if (fall && s.phase == PH_BITS && s.bitcnt == 4'h0_008)
         begin
            // no wait for transmit or the address byte
            wait_eff = s.wait_f && !s.dir && !s.addr_phase;
            if (s.addr_phase)
            begin
               n.addr_phase = 1'b0;
               n.prot = 1'b0;
               match = !s.master_slave_bit && !s.free_fmt && (s.shift[7:1] == s.own_addr);
               n.involved = s.master_slave_bit || s.free_fmt || match;
               n.amatch = match;
               // addressed for read turns to transmit
               if (match && s.shift[0])
               begin
                  n.dir = 1'b1;
               end
            end
            // lost master drops to slave after the byte
            if (s.lost)
            begin
               n.master_slave_bit = 1'b0;
               n.lost = 1'b0;
            end
            if (!n.involved)
            begin
               n.phase = PH_IDLE;
            end
            else if (s.ack_clk && s.rx_done_irq_enable && wait_eff)
            begin
               // interrupt at last data bit and hold the clock
               n.pending = 1'b0;
               n.irq = 1'b1;
               n.phase = PH_HOLD;
               n.sda_gen = 1'b1;
            end
            else if (s.ack_clk)
            begin
               n.phase = PH_ACK;
               n.sda_gen = n.dir ? 1'b1 : s.ack_bit;
            end
            else
            begin
               n.pending = 1'b0;
               n.irq = 1'b1;
               n.phase = PH_DONE;
               n.sda_gen = n.dir ? n.shift[7] : 1'b1;
            end
         end
         if (fall && s.phase == PH_ACK)
         begin
            // request at the falling edge of the ack clock
            n.pending = 1'b0;
            n.irq = 1'b1;
            n.phase = PH_DONE;
            n.sda_gen = 1'b1;
         end
         if (start_c)
         begin
            n.busy = 1'b1;
            // protection from busy rise until address received
            n.prot = 1'b1;
            n.addr_phase = 1'b1;
            n.involved = 1'b1;
            n.dir = 1'b0;
            n.master_slave_bit = 1'b0;
            n.amatch = 1'b0;
            n.wait_f = 1'b0;
            n.bitcnt = 4'h0_000;
            n.phase = PH_BITS;
            n.sda_gen = 1'b1;
         end
         if (stop_c)
         begin
            n.busy = 1'b0;
            n.dir = 1'b0;
            n.master_slave_bit = 1'b0;
            n.prot = 1'b0;
            n.phase = PH_IDLE;
            n.scl_gen = 1'b1;
            n.sda_gen = 1'b1;
            if (s.sim)
            begin
               n.irq = 1'b1;
            end
         end
      end

      // disable or soft reset clears the bus state
      if (!n.enable || (wr && PADDR == `ISC_OFF_CTRL_ZERO && PWDATA[`ISC_C0_SRST]))
      begin
         n.busy = 1'b0;
         n.dir = 1'b0;
         n.master_slave_bit = 1'b0;
         n.pending = 1'b1;
         n.al = 1'b0;
         n.amatch = 1'b0;
         n.lost = 1'b0;
         n.prot = 1'b0;
         n.addr_phase = 1'b0;
         n.wait_f = 1'b0;
         n.acc = 5'h0_000;
         n.hi_cnt = 5'h0_000;
         n.bitcnt = 4'h0_000;
         n.half = 4'h0_000;
         n.phase = PH_IDLE;
         n.scl_gen = 1'b1;
         n.sda_gen = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         s <= '0;
         s.pending <= 1'b1;
         s.scl_gen <= 1'b1;
         s.sda_gen <= 1'b1;
         s.s1_scl <= 1'b1;
         s.s2_scl <= 1'b1;
         s.s1_sda <= 1'b1;
         s.s2_sda <= 1'b1;
         s.scl_q <= 1'b1;
         s.sda_q <= 1'b1;
         s.phase <= PH_IDLE;
         s.sstime <= `ISC_RST_TIMING;
         s.own_addr <= `ISC_RST_OWN_ADDR;
      end
      else
      begin
         s <= n;
      end
   end

   // override drives pins from port latches while enabled
   assign SCL_OE = s.enable && !(s.clock_pin_override ? s.latch_scl : scl_int);
   assign SDA_OE = s.enable && !(s.data_pin_override ? s.latch_sda : s.sda_gen);
   assign SCL_O = 1'b0;
   assign SDA_O = 1'b0;
   assign PRDATA = s.prdata;
   assign PREADY = 1'b1;
   assign PSLVERR = s.slverr;
   assign IRQ = s.irq;
endmodule
`default_nettype wire

// File: verification/isc_status_mode_ctrl_chk.sv
// Port checker of the two-wire status block.
`timescale 1ns/1ps
`default_nettype none
module isc_status_mode_ctrl_chk (
   // Clock and reset.
   input wire logic CLK,
   input wire logic SRST,
   // APB slave.
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   // Bus pins and request.
   input wire logic SCL_O,
   input wire logic SCL_OE,
   input wire logic SDA_O,
   input wire logic SDA_OE,
   input wire logic IRQ
);
   logic en;
   logic data_pin_override;
   logic clock_pin_override;
   logic [1:0] lat;
   wire logic wr = PSEL && PENABLE && PWRITE;
   // Shadow of the enable, override and latch bits, updated at the write edge.
   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         en <= 1'b0;
         data_pin_override <= 1'b0;
         clock_pin_override <= 1'b0;
         lat <= 2'b00;
      end
      else if (wr)
      begin
         if (PADDR == 8'h08)
            en <= PWDATA[3];
         if (PADDR == 8'h04)
            data_pin_override <= PWDATA[2];
         if (PADDR == 8'h04)
            clock_pin_override <= PWDATA[3];
         if (PADDR == 8'h1C)
            lat <= PWDATA[1:0];
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);
   sequence access_s;
      PSEL && PENABLE;
   endsequence
   sequence read_s(logic [7:0] a);
      PSEL && PENABLE && !PWRITE && PADDR == a;
   endsequence
   ready_const_a: assert property (PSEL |-> PREADY) else $error("pready low");
   pin_level_a: assert property (!SCL_O && !SDA_O) else $error("pin output not low");
   unmapped_err_a: assert property (access_s |-> PSLVERR == (PADDR[1:0] != 2'b00 || PADDR > 8'h20))
      else $error("pslverr wrong");
   rdata_upper_a: assert property (read_s(PADDR) |-> PRDATA[31:8] == 24'h00_0000) else $error("upper read bits");
   irq_pulse_a: assert property ($rose(IRQ) |=> !IRQ) else $error("irq longer than one cycle");
   off_release_a: assert property (!en |-> !SCL_OE && !SDA_OE) else $error("pin driven while off");
   data_override_a: assert property (en && data_pin_override |-> SDA_OE == !lat[0]) else $error("data override");
   clock_override_a: assert property (en && clock_pin_override |-> SCL_OE == !lat[1]) else $error("clock override");
   off_status_a: assert property (read_s(8'h00) ##0 !en |-> PRDATA[7:4] == 4'h1) else $error("status off");
   soft_reset_a: assert property (read_s(8'h08) |-> !PRDATA[6]) else $error("soft reset reads one");
endmodule
bind isc_status_mode_ctrl isc_status_mode_ctrl_chk i_chk (.CLK(CLK), .SRST(SRST), .PSEL(PSEL),
   .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
   .PSLVERR(PSLVERR), .SCL_O(SCL_O), .SCL_OE(SCL_OE), .SDA_O(SDA_O), .SDA_OE(SDA_OE), .IRQ(IRQ));
`default_nettype wire

// File: verification/isc_bus_model.sv
// Behavioural model of another master on the two-wire bus.
`timescale 1ns/1ps
`default_nettype none
module isc_bus_model (
   // Clock.
   input wire logic clk,
   // Device enables and line levels.
   input wire logic scl_oe,
   input wire logic sda_oe,
   output logic scl_i,
   output logic sda_i
);
   logic scl_pull = 1'b0;
   logic sda_pull = 1'b0;
   // Open-drain lines with pull-ups: a released line reads high.
   assign scl_i = !(scl_oe || scl_pull);
   assign sda_i = !(sda_oe || sda_pull);
   task automatic hold(input int n);
      repeat (n) @(posedge clk);
   endtask
   // One START or STOP, the clock high for hold_hi cycles before the data edge.
   task automatic cond(input logic is_start, input int hold_hi);
      scl_pull <= 1'b1;
      hold(8);
      sda_pull <= !is_start;
      hold(8);
      scl_pull <= 1'b0;
      hold(hold_hi);
      sda_pull <= is_start;
      hold(8);
   endtask
   // One data bit: the data line changes while the clock is low, then the clock is released.
   task automatic bit_out(input logic b);
      scl_pull <= 1'b1;
      hold(8);
      sda_pull <= !b;
      hold(8);
      scl_pull <= 1'b0;
      hold(16);
   endtask
endmodule
`default_nettype wire

// File: verification/isc_status_mode_ctrl_tb.sv
// Self-checking bench of the two-wire status block.
`timescale 1ns/1ps
`default_nettype none
module isc_status_mode_ctrl_tb;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic [31:0] seed = 32'h0000_139d;
   logic [7:0] w;
   logic pready, pslverr, err, scl_i, scl_o, scl_oe, sda_i, sda_o, sda_oe, irq;
   int failures = 0;
   int total_checks = 0;
   int irq_count = 0;
   int n0;
   always #10 clk = !clk;
   always @(negedge clk)
      if (irq === 1'b1)
         irq_count++;
   isc_status_mode_ctrl i_dut (.CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .SCL_I(scl_i),
      .SCL_O(scl_o), .SCL_OE(scl_oe), .SDA_I(sda_i), .SDA_O(sda_o), .SDA_OE(sda_oe), .WAIT_MODE(1'b0),
      .STOP_MODE(1'b0), .IRQ(irq));
   isc_bus_model i_bus (.clk(clk), .scl_oe(scl_oe), .sda_oe(sda_oe), .scl_i(scl_i), .sda_i(sda_i));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20)
      begin
         @(posedge clk);
         n++;
      end
      if (n == 20)
      begin
         failures++;
         end_of_test();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rdc(input string name, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      apb(1'b0, a, 32'h0000_0000);
      check(name, rd & {24'h00_0000, m}, {24'h00_0000, e});
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      rdc("status reset", 8'h00, 8'hFF, 8'h10);
      rdc("timing reset", 8'h10, 8'h1F, 8'h0A);
      apb(1'b0, 8'h24, 32'h0000_0000);
      check("unmapped", {31'h0000_0000, err}, 32'h0000_0001);
      // Control one read-back while off: monitors masked, wait flag still clear.
      repeat (4)
      begin
         // receive-done enable stays 0 while the ack clock is off.
         w = $random(seed) & 8'hCD;
         apb(1'b1, 8'h04, {24'h00_0000, w});
         rdc("ctrl one", 8'h04, 8'hCF, w & 8'hCD);
      end
      // A long clock-high time keeps latch toggling under override from looking like a condition.
      apb(1'b1, 8'h10, 32'h0000_001E);
      apb(1'b1, 8'h08, 32'h0000_0008);
      apb(1'b1, 8'h04, 32'h0000_0000);
      // Pins follow random latch values under override.
      repeat (4)
      begin
         w = $random(seed) & 8'h03;
         apb(1'b1, 8'h1C, {24'h00_0000, w});
         apb(1'b1, 8'h04, 32'h0000_000C);
         @(negedge clk);
         check("sda override", {31'h0000_0000, sda_oe}, {31'h0000_0000, !w[0]});
         check("scl override", {31'h0000_0000, scl_oe}, {31'h0000_0000, !w[1]});
         @(posedge clk);
      end
      apb(1'b1, 8'h04, 32'h0000_0001);
      i_bus.cond(1'b1, 20);
      rdc("short start", 8'h00, 8'h20, 8'h00);
      i_bus.cond(1'b0, 20);
      i_bus.cond(1'b1, 100);
      rdc("busy set", 8'h00, 8'h20, 8'h20);
      apb(1'b1, 8'h00, 32'h0000_00D0);
      rdc("protected", 8'h00, 8'hC0, 8'h00);
      n0 = irq_count;
      i_bus.cond(1'b0, 100);
      i_bus.hold(20);
      check("stop irq", irq_count, n0 + 1);
      rdc("after stop", 8'h00, 8'hF0, 8'h10);
      apb(1'b1, 8'h00, 32'h0000_00D0);
      rdc("mode set", 8'h00, 8'hC0, 8'hC0);
      i_bus.cond(1'b1, 100);
      rdc("start clears", 8'h00, 8'hC0, 8'h00);
      apb(1'b1, 8'h08, 32'h0000_0048);
      rdc("soft reset", 8'h00, 8'hE0, 8'h00);
      i_bus.cond(1'b0, 100);
      apb(1'b1, 8'h00, 32'h0000_00D0);
      apb(1'b1, 8'h08, 32'h0000_0000);
      rdc("disabled", 8'h00, 8'hF0, 8'h10);
      // Slave receive with ack clock and receive-done wait, random own address, write direction.
      w = $random(seed) & 8'h7F;
      apb(1'b1, 8'h08, 32'h0000_0008);
      apb(1'b1, 8'h20, {24'h00_0000, w});
      // ack clock enabled before receive-done enable.
      apb(1'b1, 8'h18, 32'h0000_0002);
      apb(1'b1, 8'h04, 32'h0000_0003);
      n0 = irq_count;
      i_bus.cond(1'b1, 100);
      for (int i = 6; i >= 0; i--)
         i_bus.bit_out(w[i]);
      i_bus.bit_out(1'b0);
      i_bus.bit_out(1'b1);
      check("addr ack", {31'h0000_0000, sda_oe}, 32'h0000_0001);
      w = $random(seed);
      i_bus.bit_out(w[7]);
      check("addr irq", irq_count, n0 + 1);
      rdc("addr match", 8'h00, 8'hFF, 8'h24);
      // data write restarts after the ack clock request.
      apb(1'b1, 8'h14, 32'h0000_00FF);
      rdc("wait set", 8'h04, 8'h02, 8'h02);
      for (int i = 6; i >= 0; i--)
         i_bus.bit_out(w[i]);
      i_bus.bit_out(1'b1);
      check("last bit irq", irq_count, n0 + 2);
      check("clock held", {31'h0000_0000, scl_i}, 32'h0000_0000);
      rdc("rx data", 8'h14, 8'hFF, w);
      rdc("held status", 8'h00, 8'hFF, 8'h20);
      // ack bit written, then pending set, no data write.
      apb(1'b1, 8'h18, 32'h0000_0002);
      apb(1'b1, 8'h00, 32'h0000_0010);
      check("ack driven", {31'h0000_0000, sda_oe}, 32'h0000_0001);
      rdc("wait clear", 8'h04, 8'h02, 8'h00);
      i_bus.bit_out(1'b1);
      check("ack clock irq", irq_count, n0 + 3);
      apb(1'b1, 8'h00, 32'h0000_0010);
      i_bus.cond(1'b0, 100);
      check("final stop irq", irq_count, n0 + 4);
      rdc("final stop", 8'h00, 8'hF0, 8'h10);
      end_of_test();
   end
endmodule
`default_nettype wire
